// ### hdl/epic_regs.svh
/*
 Register offsets, field positions, reset values and timing counts of the
 encoder pulse input conditioning block.
 Assumes a 32-bit classic Wishbone slave, byte addresses, one word per register.
*/
`ifndef EPIC_REGS_SVH
`define EPIC_REGS_SVH

// =====================================
// Register offsets
`define EPIC_CTRL_OFS 8'h00
`define EPIC_PPR_OFS 8'h04
`define EPIC_ERRLVL_OFS 8'h08
`define EPIC_STAT_OFS 8'h0c
`define EPIC_MASK_OFS 8'h10
`define EPIC_SPEED_OFS 8'h14

// =====================================
// Control fields
`define EPIC_CTRL_MODE_LSB 0
`define EPIC_CTRL_TYPE_LSB 2
`define EPIC_CTRL_PM_BIT 6
`define EPIC_CTRL_RUNREV_BIT 7

// =====================================
// Status fields
`define EPIC_ST_ERR_BIT 0
`define EPIC_ST_CFG_BIT 1
`define EPIC_ST_ZERO_BIT 2
`define EPIC_ST_DIR_BIT 3
`define EPIC_ST_LIVE_LSB 8

// =====================================
// Reset values
`define EPIC_CTRL_RST 32'h0000_0001
`define EPIC_PPR_RST 32'h0000_0400
`define EPIC_ERRLVL_RST 32'h0000_0100
`define EPIC_MASK_RST 32'h0000_0000

// =====================================
// Timing
`define EPIC_CLK_HZ 50000000
`define EPIC_WIN_US 2000
`define EPIC_WIN_CYC ((`EPIC_CLK_HZ / 1000000) * `EPIC_WIN_US)

`endif

// ### hdl/epic_pkg.sv
/*
 Types of the encoder pulse input conditioning block.
 Assumes the offsets and counts of epic_regs.svh.
*/
package epic_pkg;
   typedef enum logic [1:0] {EPIC_MODE_RSV0, EPIC_MODE_TWO, EPIC_MODE_ONE, EPIC_MODE_RSV3} epic_mode_e;
   typedef logic [3:0] epic_type_t;
   typedef logic [31:0] epic_word_t;
endpackage

// ### hdl/epic_cond_if.sv
/*
 Carrier between the top and the phase conditioner.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface epic_cond_if;
   logic a_raw;
   logic b_raw;
   logic z_raw;
   logic [3:0] ptype;
   logic a_c;
   logic b_c;
   logic z_c;
   modport top (output a_raw, output b_raw, output z_raw, output ptype, input a_c, input b_c, input z_c);
   modport cond (input a_raw, input b_raw, input z_raw, input ptype, output a_c, output b_c, output z_c);
endinterface

// ### hdl/epic_cond.sv
/*
 Phase conditioner: per-input inversion, then optional A/B interchange, then
 registered output. Assumes inputs already synchronised.
*/
`timescale 1ns/1ps
module epic_cond (
   // System
   input wire logic clk,
   input wire logic rst_b,
   // Phases
   epic_cond_if.cond cif
);
   import epic_pkg::*;
   logic a_inv, b_inv, z_inv;
   logic a_reg, b_reg, z_reg, a_next, b_next, z_next;

   // =====================================
   // Inversion then swap
   always_comb begin
      a_inv = cif.a_raw ^ cif.ptype[0];
      b_inv = cif.b_raw ^ cif.ptype[1];
      z_inv = cif.z_raw ^ cif.ptype[2];
      a_next = cif.ptype[3] ? b_inv : a_inv;
      b_next = cif.ptype[3] ? a_inv : b_inv;
      z_next = z_inv;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         a_reg <= 1'b0;
         b_reg <= 1'b0;
         z_reg <= 1'b0;
      end else begin
         a_reg <= a_next;
         b_reg <= b_next;
         z_reg <= z_next;
      end
   end

   assign cif.a_c = a_reg;
   assign cif.b_c = b_reg;
   assign cif.z_c = z_reg;

   a_cond_swap: assert property (@(posedge clk) disable iff (!rst_b)
      cif.ptype[3] |=> a_reg == ($past(cif.b_raw) ^ $past(cif.ptype[1])))
      else $error("A/B interchange wrong");
endmodule // epic_cond

// ### hdl/epic_top.sv
/*
 Encoder pulse input conditioning: synchronises encoder A, B and zero-mark
 pins, conditions them, decodes direction and counts pulses, measures speed
 per 2 ms window and flags speed detection errors; Wishbone register slave.
 Assumes one 50 MHz clock and an encoder whose edges are slower than 3 clocks.
*/
// Contract
// - Mode 1 takes two quadrature phases for direction and speed.
// - Single-phase mode takes direction from the run command direction.
// - Single-phase mode together with permanent magnet control is refused.
// - Two-phase direction follows which conditioned phase leads.
// - Zero mark used only for zero detection under permanent magnet control.
// - Type bit 0 inverts A, bit 1 inverts B, bit 2 inverts zero.
// - Types 8 to 15 swap A and B.
// - Speed change per 2 ms above the error level flags an error.
`timescale 1ns/1ps
`include "epic_regs.svh"
module epic_top #(
   parameter int WIN_CYC = `EPIC_WIN_CYC
) (
   // System
   input wire logic REF_CLK,
   input wire logic RST_B,
   // Encoder pins
   input wire logic ENC_A,
   input wire logic ENC_B,
   input wire logic ENC_Z,
   // Wishbone
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire epic_pkg::epic_word_t WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // Interrupt
   output logic IRQ
);
   import epic_pkg::*;

   // =====================================
   // Pin synchronisers
   logic [2:0] s1_reg, s2_reg;
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         s1_reg <= 3'h0;
         s2_reg <= 3'h0;
      end else begin
         s1_reg <= {ENC_Z, ENC_B, ENC_A};
         s2_reg <= s1_reg;
      end
   end

   // =====================================
   // Registers
   logic [31:0] ctrl_reg, ctrl_next, ppr_reg, ppr_next, lvl_reg, lvl_next, mask_reg, mask_next;
   logic [3:0] stat_reg, stat_next;
   logic [31:0] dat_reg, dat_next;
   logic ack_reg, ack_next, irq_reg, irq_next;
   epic_mode_e mode;
   logic pm_ctl, run_rev, cfg_bad;

   assign mode = epic_mode_e'(ctrl_reg[`EPIC_CTRL_MODE_LSB +: 2]);
   assign pm_ctl = ctrl_reg[`EPIC_CTRL_PM_BIT];
   assign run_rev = ctrl_reg[`EPIC_CTRL_RUNREV_BIT];
   assign cfg_bad = (mode == EPIC_MODE_ONE) && pm_ctl;

   // =====================================
   // Conditioner
   epic_cond_if cif ();
   assign cif.a_raw = s2_reg[0];
   assign cif.b_raw = (mode == EPIC_MODE_ONE) ? 1'b0 : s2_reg[1];
   assign cif.z_raw = s2_reg[2];
   assign cif.ptype = ctrl_reg[`EPIC_CTRL_TYPE_LSB +: 4];

   epic_cond u_cond (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .cif(cif.cond)
   );

   // =====================================
   // Direction and counting
   logic a_d_reg, b_d_reg, z_d_reg, dir_reg, dir_next;
   logic [31:0] cnt_reg, cnt_next;
   logic step, step_dir, zero_ev;
   always_comb begin
      step = 1'b0;
      step_dir = dir_reg;
      zero_ev = 1'b0;
      if (!cfg_bad) begin
         if (mode == EPIC_MODE_TWO) begin
            // Quadrature: edge on one phase, level of other gives lead
            if (cif.a_c != a_d_reg) begin
               step = 1'b1;
               step_dir = ~(cif.a_c ^ cif.b_c);
            end else if (cif.b_c != b_d_reg) begin
               step = 1'b1;
               step_dir = cif.a_c ^ cif.b_c;
            end
         end else if (mode == EPIC_MODE_ONE) begin
            if (cif.a_c && !a_d_reg) begin
               step = 1'b1;
               step_dir = run_rev;
            end
         end
         zero_ev = pm_ctl && cif.z_c && !z_d_reg;
      end
      dir_next = step ? step_dir : dir_reg;
      cnt_next = step ? (step_dir ? cnt_reg - 32'h1 : cnt_reg + 32'h1) : cnt_reg;
   end

   // =====================================
   // Speed window
   logic [31:0] win_reg, win_next, spd_reg, spd_next, base_reg, base_next;
   logic [31:0] delta, dev;
   logic err_ev;
   always_comb begin
      win_next = win_reg + 32'h1;
      spd_next = spd_reg;
      base_next = base_reg;
      err_ev = 1'b0;
      delta = cnt_reg - base_reg;
      dev = (delta > spd_reg) ? delta - spd_reg : spd_reg - delta;
      if (win_reg == 32'(WIN_CYC - 1)) begin
         win_next = 32'h0;
         base_next = cnt_reg;
         spd_next = delta;
         err_ev = !cfg_bad && (dev > lvl_reg);
      end
   end

   // =====================================
   // Bus slave and status
   logic sel_hit, rd_stat;
   logic [31:0] wmask;
   always_comb begin
      sel_hit = WB_CYC_I && WB_STB_I && !ack_reg;
      rd_stat = sel_hit && !WB_WE_I && (WB_ADR_I == `EPIC_STAT_OFS);
      wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
      ctrl_next = ctrl_reg;
      ppr_next = ppr_reg;
      lvl_next = lvl_reg;
      mask_next = mask_reg;
      ack_next = sel_hit;
      dat_next = 32'h0;
      if (sel_hit && WB_WE_I) begin
         unique case (WB_ADR_I)
            `EPIC_CTRL_OFS: ctrl_next = (ctrl_reg & ~wmask) | (WB_DAT_I & wmask);
            `EPIC_PPR_OFS: ppr_next = (ppr_reg & ~wmask) | (WB_DAT_I & wmask);
            `EPIC_ERRLVL_OFS: lvl_next = (lvl_reg & ~wmask) | (WB_DAT_I & wmask);
            `EPIC_MASK_OFS: mask_next = (mask_reg & ~wmask) | (WB_DAT_I & wmask);
            default: ;
         endcase
      end else if (sel_hit) begin
         unique case (WB_ADR_I)
            `EPIC_CTRL_OFS: dat_next = ctrl_reg;
            `EPIC_PPR_OFS: dat_next = ppr_reg;
            `EPIC_ERRLVL_OFS: dat_next = lvl_reg;
            `EPIC_STAT_OFS: dat_next = {21'h0, cif.z_c, cif.b_c, cif.a_c, cfg_bad, 3'h0, stat_reg};
            `EPIC_MASK_OFS: dat_next = mask_reg;
            `EPIC_SPEED_OFS: dat_next = spd_reg;
            default: dat_next = 32'h0;
         endcase
      end
      // Read clears; a new event in the same cycle wins
      stat_next = rd_stat ? 4'h0 : stat_reg;
      if (err_ev) stat_next[`EPIC_ST_ERR_BIT] = 1'b1;
      if (cfg_bad) stat_next[`EPIC_ST_CFG_BIT] = 1'b1;
      if (zero_ev) stat_next[`EPIC_ST_ZERO_BIT] = 1'b1;
      if (step && step_dir != dir_reg) stat_next[`EPIC_ST_DIR_BIT] = 1'b1;
      irq_next = |(stat_next & mask_reg[3:0]);
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         ctrl_reg <= `EPIC_CTRL_RST;
         ppr_reg <= `EPIC_PPR_RST;
         lvl_reg <= `EPIC_ERRLVL_RST;
         mask_reg <= `EPIC_MASK_RST;
         stat_reg <= 4'h0;
         dat_reg <= 32'h0;
         ack_reg <= 1'b0;
         irq_reg <= 1'b0;
         a_d_reg <= 1'b0;
         b_d_reg <= 1'b0;
         z_d_reg <= 1'b0;
         dir_reg <= 1'b0;
         cnt_reg <= 32'h0;
         win_reg <= 32'h0;
         spd_reg <= 32'h0;
         base_reg <= 32'h0;
      end else begin
         ctrl_reg <= ctrl_next;
         ppr_reg <= ppr_next;
         lvl_reg <= lvl_next;
         mask_reg <= mask_next;
         stat_reg <= stat_next;
         dat_reg <= dat_next;
         ack_reg <= ack_next;
         irq_reg <= irq_next;
         a_d_reg <= cif.a_c;
         b_d_reg <= cif.b_c;
         z_d_reg <= cif.z_c;
         dir_reg <= dir_next;
         cnt_reg <= cnt_next;
         win_reg <= win_next;
         spd_reg <= spd_next;
         base_reg <= base_next;
      end
   end

   assign WB_DAT_O = dat_reg;
   assign WB_ACK_O = ack_reg;
   assign IRQ = irq_reg;

   // =====================================
   // Checks
   a_one_phase_dir: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      (mode == EPIC_MODE_ONE && !pm_ctl && cif.a_c && !a_d_reg) |=> dir_reg == $past(run_rev))
      else $error("Single-phase direction not from run command");
   a_pm_refused: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      cfg_bad |=> (cnt_reg == $past(cnt_reg)) && stat_reg[1])
      else $error("Single-phase counted under permanent magnet control");
   a_quad_fwd: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      (mode == EPIC_MODE_TWO && !pm_ctl && cif.a_c && !a_d_reg && !cif.b_c) |=> !dir_reg)
      else $error("Leading A not forward");
   a_quad_rev: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      (mode == EPIC_MODE_TWO && !pm_ctl && cif.b_c && !b_d_reg && cif.a_c == a_d_reg && !cif.a_c) |=> dir_reg)
      else $error("Leading B not reverse");
   a_quad_count: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      (mode == EPIC_MODE_TWO && !pm_ctl && cif.a_c != a_d_reg) |=> cnt_reg != $past(cnt_reg))
      else $error("Quadrature edge not counted");
   a_one_rise_only: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      (mode == EPIC_MODE_ONE && !(cif.a_c && !a_d_reg)) |=> cnt_reg == $past(cnt_reg))
      else $error("Single-phase count without rising A");
   a_idle_hold: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      (mode != EPIC_MODE_ONE && mode != EPIC_MODE_TWO) |=> cnt_reg == $past(cnt_reg))
      else $error("Count moved in idle mode");
   a_cnt_step: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      step |=> cnt_reg != $past(cnt_reg))
      else $error("Step not counted");
   a_zero_gated: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      (!pm_ctl && !rd_stat && !stat_reg[2]) |=> !stat_reg[2])
      else $error("Zero mark used without permanent magnet control");
   a_err_flag: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      err_ev |=> stat_reg[0])
      else $error("Speed error not flagged");
   a_win_wrap: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      (win_reg == 32'(WIN_CYC - 1)) |=> (win_reg == 32'h0) && (spd_reg == $past(delta)))
      else $error("Speed window not closed");
   a_dir_event: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      (step && step_dir != dir_reg) |=> stat_reg[`EPIC_ST_DIR_BIT])
      else $error("Direction change not flagged");
   a_one_no_b: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      (mode == EPIC_MODE_ONE) |-> !cif.b_raw)
      else $error("Second phase read in single-phase mode");
   a_sync_path: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      cif.a_raw == $past(ENC_A, 2) || !$past(RST_B, 2))
      else $error("A not two-stage synchronised");
   a_swap_none: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      !cif.ptype[3] |=> cif.a_c == ($past(cif.a_raw) ^ $past(cif.ptype[0])))
      else $error("A inversion wrong without interchange");
   a_zero_inv: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      cif.z_c == ($past(cif.z_raw) ^ $past(cif.ptype[2])))
      else $error("Zero mark inversion wrong");
   a_irq_level: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      ##1 IRQ == $past(|(stat_next & mask_reg[3:0])))
      else $error("Interrupt level wrong");
   a_irq_mask: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      ($past(mask_reg[3:0]) == 4'h0) |-> !IRQ)
      else $error("Interrupt raised while fully masked");

   // =====================================
   // Bus and status checks
   a_ack_pulse: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      WB_ACK_O |=> !WB_ACK_O)
      else $error("Acknowledge longer than one cycle");
   a_ack_answer: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
      else $error("Request not answered in one cycle");
   a_dat_idle: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      !WB_ACK_O |-> WB_DAT_O == 32'h0)
      else $error("Read data not zero outside acknowledge");
   a_ctrl_write: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      (sel_hit && WB_WE_I && WB_ADR_I == `EPIC_CTRL_OFS && WB_SEL_I == 4'hf) |=> ctrl_reg == $past(WB_DAT_I))
      else $error("Control write lost");
   a_unmapped_zero: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      (sel_hit && !WB_WE_I && WB_ADR_I > `EPIC_SPEED_OFS) |=> WB_DAT_O == 32'h0)
      else $error("Unmapped read not zero");
   a_live_read: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      rd_stat |=> {WB_DAT_O[`EPIC_ST_LIVE_LSB +: 3], WB_DAT_O[7]} == $past({cif.z_c, cif.b_c, cif.a_c, cfg_bad}))
      else $error("Live status bits misplaced");
   a_stat_clear: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      (rd_stat && !err_ev && !cfg_bad && !zero_ev && !step) |=> stat_reg == 4'h0)
      else $error("Status not cleared by read");
   c_quad_rev: cover property (@(posedge REF_CLK) mode == EPIC_MODE_TWO && step && step_dir);
   c_single: cover property (@(posedge REF_CLK) mode == EPIC_MODE_ONE && step);
   c_err: cover property (@(posedge REF_CLK) err_ev);
   c_swap: cover property (@(posedge REF_CLK) cif.ptype[3] && step);
   c_zero: cover property (@(posedge REF_CLK) zero_ev);
endmodule // epic_top

// ### test/epic_enc_model.sv
/*
 Encoder model: quadrature or single-phase pulse source, one step per 8 clocks.
 Assumes one clock and run, direction and mode levels from the bench.
*/
`timescale 1ns/1ps
module epic_enc_model (
   // System
   input wire logic clk,
   input wire logic rst_b,
   // Control
   input wire logic run,
   input wire logic rev,
   input wire logic single,
   // Pins
   output logic enc_a,
   output logic enc_b,
   output logic enc_z
);
   logic [1:0] pos_reg;
   logic [2:0] div_reg;
   logic float_reg;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pos_reg <= 2'h1;
         div_reg <= 3'h0;
         float_reg <= 1'b0;
      end else begin
         float_reg <= ~float_reg;
         div_reg <= div_reg + 3'h1;
         if (run && div_reg == 3'h7) begin
            pos_reg <= (rev && !single) ? pos_reg - 2'h1 : pos_reg + 2'h1;
         end
      end
   end
   // A leads B forward; single phase leaves B floating
   assign enc_a = single ? pos_reg[0] : (pos_reg == 2'h1 || pos_reg == 2'h2);
   assign enc_b = single ? float_reg : pos_reg[1];
   assign enc_z = !single && pos_reg == 2'h0;
endmodule // epic_enc_model

// ### test/tb_epic_top.sv
/*
 Testbench of the encoder pulse input conditioning block.
 Assumes epic_top, epic_enc_model and a 50 MHz clock.
*/
`timescale 1ns/1ps
`include "epic_regs.svh"
module tb_epic_top;
   import epic_pkg::*;
   localparam int WIN = 64;
   logic clk, rst_b, cyc, stb, we, ack, irq, run, rev, single, ea, eb, ez;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [3:0] t;
   epic_word_t wdat;
   logic [31:0] rdo, rdat;
   int num_errors, tests_run, cycles;
   epic_top #(.WIN_CYC(WIN)) i_epic_top (.REF_CLK(clk), .RST_B(rst_b), .ENC_A(ea), .ENC_B(eb), .ENC_Z(ez),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
      .WB_DAT_O(rdo), .WB_ACK_O(ack), .IRQ(irq));
   epic_enc_model i_epic_enc_model (.clk(clk), .rst_b(rst_b), .run(run), .rev(rev), .single(single),
      .enc_a(ea), .enc_b(eb), .enc_z(ez));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // ==========================
   // Reporting and bus tasks
   task automatic stop_test();
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         stop_test();
      end
   end
   task automatic wb(input logic w, input logic [7:0] a, input epic_word_t d, input logic [3:0] s);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rdat = rdo;
      chk("ack", 32'h1, {31'h0, ack});
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
      wb(1'b0, a, 32'h0, 4'hf);
      chk(nm, e, rdat);
   endtask
   task automatic spd(input logic neg);
      repeat (4 * WIN) @(posedge clk);
      wb(1'b0, `EPIC_SPEED_OFS, 32'h0, 4'hf);
      chk("speed_sign", {31'h0, neg}, {31'h0, rdat[31]});
      chk("speed_nonzero", 32'h1, {31'h0, |rdat});
   endtask
   // ==========================
   // Main sequence
   initial begin
      rst_b = 1'b0;
      {cyc, stb, we, run, rev, single} = 6'h0;
      adr = 8'h0;
      sel = 4'h0;
      wdat = 32'h0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rc(`EPIC_CTRL_OFS, `EPIC_CTRL_RST, "ctrl_reset");
      rc(`EPIC_PPR_OFS, `EPIC_PPR_RST, "ppr_reset");
      rc(`EPIC_ERRLVL_OFS, `EPIC_ERRLVL_RST, "errlvl_reset");
      rc(`EPIC_MASK_OFS, `EPIC_MASK_RST, "mask_reset");
      wb(1'b1, `EPIC_PPR_OFS, 32'h0000_1234, 4'hf);
      wb(1'b1, `EPIC_PPR_OFS, 32'hffff_ffff, 4'h1);
      rc(`EPIC_PPR_OFS, 32'h0000_12ff, "ppr_lane");
      wb(1'b1, 8'h18, 32'hffff_ffff, 4'hf);
      rc(8'h18, 32'h0, "unmapped");
      for (int i = 0; i < 16; i++) begin
         t = i[3:0];
         wb(1'b1, `EPIC_CTRL_OFS, {26'h0, t, 2'b01}, 4'hf);
         repeat (4) @(posedge clk);
         wb(1'b0, `EPIC_STAT_OFS, 32'h0, 4'hf);
         chk("live", t[3] ? {29'h0, t[2], ~t[0], t[1]} : {29'h0, t[2], t[1], ~t[0]}, {29'h0, rdat[10:8]});
      end
      wb(1'b1, `EPIC_ERRLVL_OFS, 32'h2, 4'hf);
      wb(1'b1, `EPIC_CTRL_OFS, 32'h1, 4'hf);
      run <= 1'b1;
      spd(1'b0);
      wb(1'b0, `EPIC_STAT_OFS, 32'h0, 4'hf);
      repeat (3 * WIN) @(posedge clk);
      wb(1'b0, `EPIC_STAT_OFS, 32'h0, 4'hf);
      chk("steady_events", 32'h0, {28'h0, rdat[3:0]});
      rev <= 1'b1;
      spd(1'b1);
      chk("irq_masked", 32'h0, {31'h0, irq});
      wb(1'b1, `EPIC_MASK_OFS, 32'h1, 4'hf);
      chk("irq_raised", 32'h1, {31'h0, irq});
      wb(1'b0, `EPIC_STAT_OFS, 32'h0, 4'hf);
      chk("reversal_events", 32'h9, {28'h0, rdat[3:0] & 4'h9});
      repeat (2) @(posedge clk);
      chk("irq_cleared", 32'h0, {31'h0, irq});
      wb(1'b1, `EPIC_CTRL_OFS, 32'h41, 4'hf);
      repeat (WIN) @(posedge clk);
      wb(1'b0, `EPIC_STAT_OFS, 32'h0, 4'hf);
      chk("zero_mark", 32'h1, {31'h0, rdat[2]});
      single <= 1'b1;
      wb(1'b1, `EPIC_CTRL_OFS, 32'h02, 4'hf);
      spd(1'b0);
      wb(1'b1, `EPIC_CTRL_OFS, 32'h00, 4'hf);
      repeat (3 * WIN) @(posedge clk);
      rc(`EPIC_SPEED_OFS, 32'h0, "idle_speed");
      wb(1'b1, `EPIC_CTRL_OFS, 32'h82, 4'hf);
      spd(1'b1);
      wb(1'b1, `EPIC_CTRL_OFS, 32'hc2, 4'hf);
      repeat (3 * WIN) @(posedge clk);
      rc(`EPIC_SPEED_OFS, 32'h0, "refused_speed");
      wb(1'b0, `EPIC_STAT_OFS, 32'h0, 4'hf);
      chk("refused_cfg", 32'h3, {30'h0, rdat[7], rdat[1]});
      stop_test();
   end
endmodule // tb_epic_top
